// [rtl/sbg_cfg.svh]
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SBG_CFG_SVH
`define SBG_CFG_SVH
// register indices; byte address is four times the index
`define SBG_IDX_BAUD_RELOAD   8'h91
`define SBG_IDX_BAUD_CTRL     8'h92
`define SBG_IDX_SER_CTRL      8'h98
`define SBG_IDX_SER_BUF       8'h99
`define SBG_IDX_SLV_ADDR      8'hA9
`define SBG_IDX_SLV_MASK      8'hB9
`define SBG_IDX_AUX_CTRL      8'hC0
// serial control field positions
`define SBG_SC_FE_SM0         7
`define SBG_SC_SM1            6
`define SBG_SC_MP             5
`define SBG_SC_REN            4
`define SBG_SC_TB8            3
`define SBG_SC_RB8            2
`define SBG_SC_TI             1
`define SBG_SC_RI             0
// baud control field positions
`define SBG_BC_RUN            4
`define SBG_BC_TXSRC          3
`define SBG_BC_RXSRC          2
`define SBG_BC_SPD            1
`define SBG_BC_SHIFT_MODE_RATE_SOURCE          0
// aux control field positions
`define SBG_AX_ERRSEL         0
`define SBG_AX_DOUBLE         1
// reset values
`define SBG_RST_SER_CTRL      8'h00
`define SBG_RST_BAUD_CTRL     5'h00
`define SBG_RST_SLV           8'h00
`define SBG_RST_RELOAD        8'h00
// clock divisions
`define SBG_DIV_SHIFT         4'hB
`define SBG_DIV_SLOW          6'h05
`define SBG_DIV_M2            6'h1F
`define SBG_DIV_M2_DBL        6'h0F
`endif

// [rtl/sbg_pkg.sv]
// types of the serial port with baud generator
package sbg_pkg;
  typedef enum logic [1:0] {
    SBG_MODE_SHIFT = 2'b00,
    SBG_MODE_UART8 = 2'b01,
    SBG_MODE_UART9F = 2'b10,
    SBG_MODE_UART9V = 2'b11
  } sbg_mode_t;
  typedef struct packed {
    logic [7:0] data;
    logic       bit9;
    logic       stop_ok;
  } sbg_rx_frame_t;
endpackage

// [rtl/sbg_baud_gen.sv]
// internal baud generator: up-counter from reload value, overflow tick
`timescale 1ns/1ps
`include "sbg_cfg.svh"
module sbg_baud_gen (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_fast,
  input  wire logic [7:0] i_reload,
  output logic            o_tick
);
  logic [7:0] count;
  logic [5:0] pre;
  logic       pre_hit;
  // low speed divides the count clock by a prescaler
  assign pre_hit = i_fast | (pre == `SBG_DIV_SLOW);
  // prescaler
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_run || pre_hit) begin
      pre <= 6'h00;
    end else begin
      pre <= pre + 6'h01;
    end
  end
  // counter with reload on overflow, stopped when not running
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      count  <= 8'h00;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      count  <= i_reload;
      o_tick <= 1'b0;
    end else if (pre_hit) begin
      if (count == 8'hFF) begin
        count  <= i_reload;
        o_tick <= 1'b1;
      end else begin
        count  <= count + 8'h01;
        o_tick <= 1'b0;
      end
    end else begin
      o_tick <= 1'b0;
    end
  end
  AST_TICK_NEEDS_RUN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_tick |-> $past(i_run)) else $error("tick while generator stopped");
endmodule

// [rtl/sbg_addr_match.sv]
// address recognition with given and broadcast address, registered result
`timescale 1ns/1ps
module sbg_addr_match (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_rx_addr,
  input  wire logic [7:0] i_slave_address,
  input  wire logic [7:0] i_slave_address_mask,
  output logic            o_match
);
  logic given_hit;
  logic bcast_hit;
  logic [7:0] bcast;
  assign bcast     = i_slave_address | i_slave_address_mask;
  // zero mask bits are don't-care
  assign given_hit = ((i_rx_addr ^ i_slave_address) & i_slave_address_mask) == 8'h00;
  // zero bits of the or are don't-care
  assign bcast_hit = ((i_rx_addr ^ bcast) & bcast) == 8'h00;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_match <= 1'b0;
    end else begin
      o_match <= given_hit | bcast_hit;
    end
  end
endmodule

// [rtl/sbg_serial_port.sv]
// serial port top: apb registers, transmitter, receiver, rate selection
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "sbg_cfg.svh"
module sbg_serial_port (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_timer1_tick,
  input  wire logic        i_rxd,
  output logic             o_txd,
  output logic             o_shift_clk
);
  import sbg_pkg::*;
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] serial_control;
  logic       mode_bit_low;
  logic [4:0] baud_gen_control;
  logic [7:0] baud_reload;
  logic [7:0] slave_address;
  logic [7:0] slave_address_mask;
  logic [7:0] serial_buffer;
  logic       error_detect_select;
  logic       rate_double;
  logic       wr_en;
  logic       rd_en;
  logic [9:0] idx;
  logic       mapped;
  logic       gen_tick;
  logic       tx_start;
  logic       tx_done;
  logic       rx_done;
  logic       rx_accept;
  logic       rx_frame_err;
  logic       addr_match;
  sbg_rx_frame_t rx_frame;
  sbg_mode_t  mode;
  assign idx    = paddr[11:2];
  assign wr_en  = psel & penable & pwrite & pready & mapped;
  assign rd_en  = psel & ~penable & ~pwrite;
  assign mapped = idx[9:8] == 2'b00 && paddr[1:0] == 2'b00 &&
                  (idx[7:0] == `SBG_IDX_BAUD_RELOAD || idx[7:0] == `SBG_IDX_BAUD_CTRL ||
                   idx[7:0] == `SBG_IDX_SER_CTRL || idx[7:0] == `SBG_IDX_SER_BUF ||
                   idx[7:0] == `SBG_IDX_SLV_ADDR || idx[7:0] == `SBG_IDX_SLV_MASK ||
                   idx[7:0] == `SBG_IDX_AUX_CTRL);
  assign mode   = sbg_mode_t'({mode_bit_low, serial_control[`SBG_SC_SM1]});
  // ----------------------------------------------------------------
  // apb slave: no wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end
  // read data captured in the setup cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !mapped) begin
      prdata <= 32'h0000_0000; // refused reads return zero
    end else if (rd_en) begin
      unique case (idx[7:0])
        `SBG_IDX_BAUD_RELOAD: prdata <= {24'h00_0000, baud_reload};
        `SBG_IDX_BAUD_CTRL:   prdata <= {27'h000_0000, baud_gen_control};
        `SBG_IDX_SER_CTRL:    prdata <= {24'h00_0000,
                                (error_detect_select ? serial_control[7] : mode_bit_low),
                                serial_control[6:0]};
        `SBG_IDX_SER_BUF:     prdata <= {24'h00_0000, serial_buffer};
        `SBG_IDX_SLV_ADDR:    prdata <= {24'h00_0000, slave_address};
        `SBG_IDX_SLV_MASK:    prdata <= {24'h00_0000, slave_address_mask};
        `SBG_IDX_AUX_CTRL:    prdata <= {30'h0000_0000, rate_double, error_detect_select};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end
  // configuration registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      baud_gen_control    <= `SBG_RST_BAUD_CTRL;
      baud_reload         <= `SBG_RST_RELOAD;
      slave_address       <= `SBG_RST_SLV;
      slave_address_mask  <= `SBG_RST_SLV;
      error_detect_select <= 1'b0;
      rate_double         <= 1'b0;
      mode_bit_low        <= 1'b0;
    end else if (wr_en && mapped) begin
      if (idx[7:0] == `SBG_IDX_BAUD_CTRL) baud_gen_control <= pwdata[4:0];
      if (idx[7:0] == `SBG_IDX_BAUD_RELOAD) baud_reload <= pwdata[7:0];
      if (idx[7:0] == `SBG_IDX_SLV_ADDR) slave_address <= pwdata[7:0];
      if (idx[7:0] == `SBG_IDX_SLV_MASK) slave_address_mask <= pwdata[7:0];
      if (idx[7:0] == `SBG_IDX_AUX_CTRL) begin
        error_detect_select <= pwdata[`SBG_AX_ERRSEL];
        rate_double         <= pwdata[`SBG_AX_DOUBLE];
      end
      if (idx[7:0] == `SBG_IDX_SER_CTRL && !error_detect_select) begin
        mode_bit_low <= pwdata[7];
      end
    end
  end
  // serial control: hardware sets win over software clears
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      serial_control <= `SBG_RST_SER_CTRL;
    end else begin
      if (wr_en && idx[7:0] == `SBG_IDX_SER_CTRL) begin
        serial_control[6:0] <= pwdata[6:0];
        if (error_detect_select) serial_control[7] <= pwdata[7];
      end
      if (tx_done) serial_control[`SBG_SC_TI] <= 1'b1;
      if (rx_accept) begin
        serial_control[`SBG_SC_RI] <= 1'b1;
        if (mode[1]) begin
          serial_control[`SBG_SC_RB8] <= rx_frame.bit9;
        end else if (mode == SBG_MODE_UART8 && !serial_control[`SBG_SC_MP]) begin
          serial_control[`SBG_SC_RB8] <= rx_frame.stop_ok;
        end
      end
      if (rx_frame_err && error_detect_select) serial_control[7] <= 1'b1;
    end
  end
  // receive buffer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      serial_buffer <= 8'h00;
    end else if (rx_accept) begin
      serial_buffer <= rx_frame.data;
    end
  end
  assign tx_start = wr_en && idx[7:0] == `SBG_IDX_SER_BUF;
  // ----------------------------------------------------------------
  // bit rate selection
  // ----------------------------------------------------------------
  sbg_baud_gen u_gen (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (baud_gen_control[`SBG_BC_RUN]),
    .i_fast    (baud_gen_control[`SBG_BC_SPD]),
    .i_reload  (baud_reload),
    .o_tick    (gen_tick)
  );
  logic [5:0] fix_cnt;
  logic [5:0] fix_lim;
  logic       fix_tick;
  logic       tx_tick;
  logic       rx_tick;
  // fixed division: shift rate in mode 0, clock/32 or /16 in mode 2
  assign fix_lim  = (mode == SBG_MODE_UART9F) ? (rate_double ? `SBG_DIV_M2_DBL : `SBG_DIV_M2)
                                              : {2'b00, `SBG_DIV_SHIFT};
  assign fix_tick = fix_cnt == fix_lim;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || fix_tick) begin
      fix_cnt <= 6'h00;
    end else begin
      fix_cnt <= fix_cnt + 6'h01;
    end
  end
  // per-direction tick selection
  always_comb begin
    unique case (mode)
      SBG_MODE_SHIFT: begin
        tx_tick = baud_gen_control[`SBG_BC_SHIFT_MODE_RATE_SOURCE] ? gen_tick : fix_tick;
        rx_tick = tx_tick;
      end
      SBG_MODE_UART9F: begin
        tx_tick = fix_tick;
        rx_tick = fix_tick;
      end
      SBG_MODE_UART8, SBG_MODE_UART9V: begin
        tx_tick = baud_gen_control[`SBG_BC_TXSRC] ? gen_tick : i_timer1_tick;
        rx_tick = baud_gen_control[`SBG_BC_RXSRC] ? gen_tick : i_timer1_tick;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // transmitter: frame shifted one bit per tick
  // ----------------------------------------------------------------
  logic [10:0] tx_sh;
  logic [3:0]  tx_left;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tx_sh   <= 11'h7FF;
      tx_left <= 4'h0;
      o_txd   <= 1'b1;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_start && tx_left == 4'h0) begin
        if (mode == SBG_MODE_SHIFT) begin
          tx_sh   <= {3'b111, pwdata[7:0]};
          tx_left <= 4'h8;
        end else if (mode[1]) begin
          tx_sh   <= {1'b1, serial_control[`SBG_SC_TB8], pwdata[7:0], 1'b0};
          tx_left <= 4'hB;
        end else begin
          tx_sh   <= {2'b11, pwdata[7:0], 1'b0};
          tx_left <= 4'hA;
        end
      end else if (tx_left != 4'h0 && tx_tick) begin
        o_txd   <= tx_sh[0];
        tx_sh   <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1) begin
          tx_done <= 1'b1;
        end
      end
    end
  end
  // shift clock out in mode 0
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_shift_clk <= 1'b1;
    end else begin
      o_shift_clk <= !(mode == SBG_MODE_SHIFT && tx_left != 4'h0 && tx_tick);
    end
  end
  // ----------------------------------------------------------------
  // receiver: samples at tick, start bit opens the frame except in mode 0
  // ----------------------------------------------------------------
  logic [9:0] rx_sh;
  logic [3:0] rx_cnt;
  logic [3:0] rx_len;
  logic       rx_end;
  logic       rx_pending;
  assign rx_len      = (mode == SBG_MODE_SHIFT) ? 4'h8 : (mode[1] ? 4'hA : 4'h9);
  assign rx_end      = rx_cnt == rx_len && rx_tick;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rx_sh      <= 10'h000;
      rx_cnt     <= 4'h0;
      rx_pending <= 1'b0;
      rx_frame   <= '0;
    end else begin
      rx_pending <= 1'b0;
      if (!serial_control[`SBG_SC_REN]) begin
        rx_cnt <= 4'h0;
      end else if (rx_tick) begin
        if (rx_cnt == 4'h0 && (mode == SBG_MODE_SHIFT || !i_rxd)) begin
          rx_cnt <= 4'h1;
          rx_sh  <= {i_rxd, 9'h000};
        end else if (rx_cnt != 4'h0) begin
          rx_sh  <= {i_rxd, rx_sh[9:1]};
          rx_cnt <= rx_end ? 4'h0 : rx_cnt + 4'h1;
          if (rx_end) begin
            rx_pending       <= 1'b1;
            rx_frame.stop_ok <= i_rxd;
            rx_frame.bit9    <= mode[1] ? rx_sh[9] : i_rxd;
            rx_frame.data    <= mode == SBG_MODE_SHIFT ? {i_rxd, rx_sh[9:3]} :
                                mode[1] ? rx_sh[8:1] : rx_sh[9:2];
          end
        end
      end
    end
  end
  sbg_addr_match u_match (
    .i_ref_clk            (i_ref_clk),
    .i_rst_n              (i_rst_n),
    .i_rx_addr            (rx_frame.data),
    .i_slave_address      (slave_address),
    .i_slave_address_mask (slave_address_mask),
    .o_match              (addr_match)
  );
  logic rx_check;
  logic mp_on;
  assign mp_on = serial_control[`SBG_SC_MP] && mode != SBG_MODE_SHIFT;
  // address compare result is ready one cycle after the frame ends
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rx_check     <= 1'b0;
      rx_accept    <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_check     <= rx_pending;
      rx_frame_err <= rx_pending && mode != SBG_MODE_SHIFT && !rx_frame.stop_ok;
      rx_accept    <= rx_check && (!mp_on || (rx_frame.bit9 && addr_match));
    end
  end
  AST_TI_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    tx_done |=> serial_control[`SBG_SC_TI]) else $error("transmit done not flagged");
  AST_RI_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rx_accept |=> serial_control[`SBG_SC_RI]) else $error("receive done not flagged");
  AST_RX_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !serial_control[`SBG_SC_REN] [*3] |=> !rx_accept) else $error("frame taken while disabled");
  AST_MP_DROP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rx_accept && mp_on |-> rx_frame.bit9) else $error("data frame taken in multiprocessor mode");
  AST_FE_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rx_frame_err && error_detect_select |=> serial_control[7]) else $error("framing error lost");
  AST_BUF_LOAD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rx_accept |=> serial_buffer == $past(rx_frame.data)) else $error("buffer not loaded");
  AST_RST_VALS: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> slave_address == 8'h00 && baud_gen_control == 5'h00) else $error("reset value wrong");
  AST_APB_WAIT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    psel && !penable |=> pready) else $error("apb answer late");
  // status flags clear only through a software write of the control register
  AST_FE_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    serial_control[7] && !(wr_en && idx[7:0] == `SBG_IDX_SER_CTRL) |=> serial_control[7])
    else $error("framing error cleared by hardware");
  AST_TI_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    serial_control[`SBG_SC_TI] && !(wr_en && idx[7:0] == `SBG_IDX_SER_CTRL) |=> serial_control[`SBG_SC_TI])
    else $error("transmit done cleared by hardware");
  AST_RI_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    serial_control[`SBG_SC_RI] && !(wr_en && idx[7:0] == `SBG_IDX_SER_CTRL) |=> serial_control[`SBG_SC_RI])
    else $error("receive done cleared by hardware");
  COV_TX: cover property (@(posedge i_ref_clk) tx_done);
  COV_RX: cover property (@(posedge i_ref_clk) rx_accept);
  COV_FE: cover property (@(posedge i_ref_clk) rx_frame_err);
  COV_SHIFT: cover property (@(posedge i_ref_clk) !o_shift_clk);
  COV_ADDR: cover property (@(posedge i_ref_clk) rx_accept && mp_on);
endmodule

// [verification/sbg_line_model.sv]
// far-side serial device: bit grid, frame sender and frame catcher
`timescale 1ns/1ps
module sbg_line_model #(
  parameter int BIT_CYC = 32
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_line,
  input  wire logic [3:0]  i_nbits,
  output logic             o_line,
  output logic             o_tick,
  output logic [10:0]      o_frame,
  output int               o_count
);
  // ----------------------------------------------------------------
  // bit grid
  // ----------------------------------------------------------------
  int cnt;
  int left;
  // idle line is high before the first frame
  initial begin
    cnt = 0;
    left = 0;
    o_line = 1'b1;
    o_tick = 1'b0;
    o_frame = '0;
    o_count = 0;
  end
  // one tick per bit time feeds the timer 1 input
  always @(posedge i_ref_clk) begin
    cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
    o_tick <= (cnt == BIT_CYC - 1);
  end
  // ----------------------------------------------------------------
  // sender and catcher
  // ----------------------------------------------------------------
  // line changes half a bit away from the tick so sampling hits mid-bit
  task automatic send(input logic [9:0] bits, input int nb);
    for (int i = -1; i < nb; i++) begin
      @(posedge i_ref_clk iff cnt == BIT_CYC / 2);
      o_line <= (i < 0) ? 1'b0 : bits[i];
    end
    @(posedge i_ref_clk iff cnt == BIT_CYC / 2);
    o_line <= 1'b1;
  endtask
  // catch start, then i_nbits bits lsb first at mid-bit
  always @(posedge i_ref_clk) begin
    if (cnt == BIT_CYC / 2) begin
      if (left == 0 && i_line === 1'b0) begin
        left <= i_nbits;
        o_frame <= '0;
      end else if (left > 0) begin
        o_frame[i_nbits - left] <= i_line;
        left <= left - 1;
        if (left == 1) begin
          o_count <= o_count + 1;
        end
      end
    end
  end
endmodule

// [verification/serial_port_with_baud_generator_test.sv]
// register-level test of the serial port over apb against a line partner
`timescale 1ns/1ps
`include "sbg_cfg.svh"
module serial_port_with_baud_generator_test;
  localparam logic [7:0] BR = `SBG_IDX_BAUD_RELOAD;
  localparam logic [7:0] BC = `SBG_IDX_BAUD_CTRL;
  localparam logic [7:0] SC = `SBG_IDX_SER_CTRL;
  localparam logic [7:0] SB = `SBG_IDX_SER_BUF;
  localparam logic [7:0] SA = `SBG_IDX_SLV_ADDR;
  localparam logic [7:0] SM = `SBG_IDX_SLV_MASK;
  localparam logic [7:0] AX = `SBG_IDX_AUX_CTRL;
  logic        i_ref_clk;
  logic        i_rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick;
  logic        rxd;
  logic        txd;
  logic        sclk;
  logic [3:0]  nbits;
  logic [10:0] frame;
  int          count;
  logic [7:0]  rdv;
  logic        errv;
  int          errors;
  int          checked;
  int          cyc;
  int          t0;
  logic [10:0] sclks;
  logic [7:0]  addrs [4] = '{8'h55, 8'h55, 8'h99, 8'hFF};
  logic        ninth [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic        hit   [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  sbg_serial_port DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_timer1_tick(tick), .i_rxd(rxd), .o_txd(txd), .o_shift_clk(sclk));
  sbg_line_model #(.BIT_CYC(32)) u_line (.i_ref_clk(i_ref_clk), .i_line(txd), .i_nbits(nbits),
    .o_line(rxd), .o_tick(tick), .o_frame(frame), .o_count(count));
  // ----------------------------------------------------------------
  // bench tasks
  // ----------------------------------------------------------------
  // free-running 125 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  // cycle count for rate checks and count of shift clock low cycles
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (sclk === 1'b0) sclks <= sclks + 11'h001;
  end
  task automatic complete_run();
    $display("checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic timeout();
    $display("unexpected wait: no answer in time");
    errors++;
    complete_run();
  endtask
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask
  // poll serial control until all bits of m are set
  task automatic wait_flag(input logic [7:0] m);
    int n;
    n = 0;
    rd(SC);
    while ((rdv & m) !== m && n < 1000) begin
      rd(SC);
      n++;
    end
    if (n >= 1000) timeout();
  endtask
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (count !== n && k < 2000) begin
      @(posedge i_ref_clk);
      k++;
    end
    if (k >= 2000) timeout();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    i_rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    nbits = 4'h9;
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    // reset values and plain register access
    rd(BC);
    check("baud control reset", rdv, 8'h00);
    rd(SA);
    check("slave address reset", rdv, 8'h00);
    wr(BR, 8'hA5);
    rd(BR);
    check("baud reload", rdv, 8'hA5);
    wr(BC, 8'h1F);
    rd(BC);
    check("baud control", rdv, 8'h1F);
    wr(BC, 8'h00);
    rd(8'h93);
    check("unmapped error", errv, 1'b1);
    // mode 1 transmit on timer 1 ticks
    wr(SC, 8'h50);
    wr(SB, 8'h3C);
    wait_flag(8'h02);
    wait_frames(1);
    check("mode 1 frame", frame[8:0], {1'b1, 8'h3C});
    wr(SC, 8'h50);
    rd(SC);
    check("tx done cleared", rdv, 8'h50);
    // mode 1 receive, then receiver disabled
    u_line.send({1'b1, 8'hC5}, 9);
    rd(SC);
    check("rx flags", rdv, 8'h55);
    rd(SB);
    check("rx byte", rdv, 8'hC5);
    rd(SC);
    check("rx done held", rdv[0], 1'b1);
    wr(SC, 8'h40);
    u_line.send({1'b1, 8'h33}, 9);
    rd(SC);
    check("rx while disabled", rdv[0], 1'b0);
    rd(SB);
    check("byte while disabled", rdv, 8'hC5);
    // bad stop bit with error detect selected
    wr(AX, 8'h01);
    wr(SC, 8'h50);
    u_line.send({1'b0, 8'h0F}, 9);
    rd(SC);
    check("framing flag", rdv[7], 1'b1);
    wr(SC, 8'h50);
    rd(SC);
    check("framing cleared", rdv[7], 1'b0);
    wr(AX, 8'h00);
    // mode 3 with ninth bit and address recognition
    wr(SA, 8'h56);
    wr(SM, 8'hFC);
    rd(SM);
    check("slave mask", rdv, 8'hFC);
    wr(SC, 8'hF8);
    rd(SC);
    check("mode bits", rdv, 8'hF8);
    nbits = 4'hA;
    wr(SB, 8'h81);
    wait_flag(8'h02);
    wait_frames(2);
    check("mode 3 frame", frame[9:0], {2'b11, 8'h81});
    for (int i = 0; i < 4; i++) begin
      wr(SC, 8'hF0);
      u_line.send({1'b1, ninth[i], addrs[i]}, 10);
      rd(SC);
      check("address frame", rdv[2:0], {hit[i], 1'b0, hit[i]});
    end
    wr(SC, 8'hD0);
    u_line.send({2'b10, 8'h99}, 10);
    rd(SC);
    check("plain mode 3", rdv[2:0], 3'b001);
    rd(SB);
    check("plain mode 3 byte", rdv, 8'h99);
    // internal generator as transmit source, stopped then running
    wr(BR, 8'hF0);
    wr(BC, 8'h0A);
    wr(SC, 8'h40);
    wr(SB, 8'h11);
    repeat (600) @(posedge i_ref_clk);
    rd(SC);
    check("tx with generator stopped", rdv[1], 1'b0);
    wr(BC, 8'h1A);
    wait_flag(8'h02);
    check("tx with generator running", rdv[1], 1'b1);
    // mode 2 at the doubled fixed rate: 11 bit times of 16 cycles to the stop bit
    repeat (40) @(posedge i_ref_clk);
    wr(AX, 8'h02);
    wr(SC, 8'h80);
    wr(SB, 8'h22);
    t0 = cyc;
    wait_flag(8'h02);
    check("mode 2 bit time", (cyc - t0) > 160 && (cyc - t0) < 200, 1'b1);
    // mode 0 at the fixed shift rate: one shift clock per bit
    repeat (40) @(posedge i_ref_clk);
    wr(SC, 8'h00);
    sclks = 11'h000;
    wr(SB, 8'h5A);
    wait_flag(8'h02);
    repeat (20) @(posedge i_ref_clk);
    check("mode 0 shift clocks", sclks, 11'h008);
    complete_run();
  end
endmodule
